// *** hdl/smbsp_port.sv ***
// Purpose: serial management-bus slave port with register pointer
// Assumes: master drives the clock; data line is open drain
// Notes:   register store lives outside; one byte read per transfer
`default_nettype none
module smbsp_port
  import smbsp_pkg::*;
#(
  parameter int TIMEOUT_CYC = SMBSP_TIMEOUT_CYC
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       address_mode_strap,
  input  wire logic       address_choice_strap,
  input  wire logic       bus_timeout_off,
  output logic [7:0]      reg_ptr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  output logic            busy,
  output logic [6:0]      own_addr
);
  // ------------------------------------------------------------------
  // line conditioning
  // ------------------------------------------------------------------
  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;

  smbsp_filter u_scl (.clk(clk), .sys_rst(sys_rst), .line_in(scl_in),
                      .line_out(scl_f));
  smbsp_filter u_sda (.clk(clk), .sys_rst(sys_rst), .line_in(sda_in),
                      .line_out(sda_f));

  wire scl_rise = scl_f && !scl_p_q;
  wire scl_fall = !scl_f && scl_p_q;
  wire start_ev = scl_f && scl_p_q && !sda_f && sda_p_q;
  wire stop_ev  = scl_f && scl_p_q && sda_f && !sda_p_q;

  // ------------------------------------------------------------------
  // address selection
  // ------------------------------------------------------------------
  logic       strap_done_q;
  logic [1:0] strap_arm_q;
  logic [1:0] mode_sync_q;
  logic [1:0] choice_sync_q;
  logic [6:0] sel_addr_q;
  logic       locked_q;
  logic [6:0] lock_addr_q;

  function automatic logic [6:0] smbsp_pick(input logic mode,
                                            input logic choice);
    if (mode) begin
      return SMBSP_ADDR_FIXED;
    end
    return choice ? SMBSP_ADDR_SEL1 : SMBSP_ADDR_SEL0;
  endfunction : smbsp_pick

  // straps are pins: two flops first, sampled once the pipe is full
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_arm_q   <= 2'b00;
      mode_sync_q   <= 2'b00;
      choice_sync_q <= 2'b00;
      strap_done_q  <= 1'b0;
      sel_addr_q    <= SMBSP_ADDR_FIXED;
    end else begin
      strap_arm_q   <= {strap_arm_q[0], 1'b1};
      mode_sync_q   <= {mode_sync_q[0], address_mode_strap};
      choice_sync_q <= {choice_sync_q[0], address_choice_strap};
      if (strap_arm_q[1] && !strap_done_q) begin
        strap_done_q <= 1'b1;
        sel_addr_q   <= smbsp_pick(mode_sync_q[1],
                                   choice_sync_q[1]);
      end
    end
  end

  wire [6:0] match_addr = locked_q ? lock_addr_q : sel_addr_q;

  // ------------------------------------------------------------------
  // transfer engine
  // ------------------------------------------------------------------
  smbsp_state_t state_q;
  logic [3:0]   bit_q;
  logic [7:0]   sh_q;
  logic         rd_q;
  logic         byte2_q;
  logic         drive_q;
  logic [7:0]   ptr_q;
  logic         wr_q;
  logic [7:0]   wdata_q;
  logic [31:0]  idle_q;

  wire [7:0] sh_next  = {sh_q[6:0], sda_f};
  wire       byte_end = scl_rise && bit_q == SMBSP_BIT_LAST;
  // after the 8th rise the address sits above the direction bit
  wire       addr_hit = sh_q[7:1] == match_addr;
  wire       to_on    = !bus_timeout_off;
  wire       activity = scl_rise || scl_fall || start_ev || stop_ev;
  wire       timeout  = to_on && state_q != SMBSP_IDLE &&
                        idle_q >= 32'(TIMEOUT_CYC - 1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      idle_q  <= 32'h0000_0000;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      idle_q  <= (activity || state_q == SMBSP_IDLE) ? 32'h0000_0000
                                                     : idle_q + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= SMBSP_IDLE;
      bit_q       <= 4'h0;
      sh_q        <= 8'h00;
      rd_q        <= 1'b0;
      byte2_q     <= 1'b0;
      drive_q     <= 1'b0;
      ptr_q       <= SMBSP_PTR_RST;
      wr_q        <= 1'b0;
      wdata_q     <= 8'h00;
      locked_q    <= 1'b0;
      lock_addr_q <= SMBSP_ADDR_FIXED;
    end else begin
      wr_q <= 1'b0;
      if (timeout || stop_ev) begin
        state_q <= SMBSP_IDLE;
        drive_q <= 1'b0;
      end else if (start_ev) begin
        state_q <= SMBSP_ADDR;
        bit_q   <= 4'h0;
        drive_q <= 1'b0;
        byte2_q <= 1'b0;
      end else begin
        case (state_q)
          SMBSP_ADDR: begin
            if (scl_rise) begin
              sh_q  <= sh_next;
              bit_q <= bit_q + 4'h1;
            end
            // bit 7 rising edge: first seven bits complete
            if (byte_end && !locked_q && sh_q[6:0] == sel_addr_q) begin
              locked_q    <= 1'b1;
              lock_addr_q <= sel_addr_q;
            end
            if (scl_fall && bit_q == SMBSP_BIT_ACK) begin
              if (addr_hit) begin
                rd_q    <= sh_q[0];
                state_q <= SMBSP_ACK;
                drive_q <= 1'b1;
              end else begin
                state_q <= SMBSP_SKIP;
              end
            end
          end
          SMBSP_ACK: begin
            if (scl_fall) begin
              bit_q <= 4'h0;
              if (rd_q) begin
                state_q <= SMBSP_RDAT;
                sh_q    <= reg_rdata;
                drive_q <= !reg_rdata[7];
              end else begin
                state_q <= SMBSP_WDAT;
                drive_q <= 1'b0;
              end
            end
          end
          SMBSP_WDAT: begin
            if (scl_rise) begin
              sh_q  <= sh_next;
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == SMBSP_BIT_ACK) begin
              if (!byte2_q) begin
                ptr_q <= sh_q;
              end else begin
                wr_q    <= 1'b1;
                wdata_q <= sh_q;
              end
              byte2_q <= 1'b1;
              state_q <= SMBSP_ACK;
              drive_q <= 1'b1;
            end
          end
          SMBSP_RDAT: begin
            if (scl_fall) begin
              bit_q <= bit_q + 4'h1;
              sh_q  <= {sh_q[6:0], 1'b1};
              if (bit_q == SMBSP_BIT_LAST) begin
                state_q <= SMBSP_RACK;
                drive_q <= 1'b0;
              end else begin
                drive_q <= !sh_q[6];
              end
            end
          end
          SMBSP_RACK: begin
            // single byte read; master no-acks then stops
            if (scl_fall) begin
              state_q <= SMBSP_SKIP;
            end
          end
          SMBSP_SKIP: begin
            drive_q <= 1'b0;
          end
          default: begin
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out   = 1'b0;
  assign sda_oe    = drive_q;
  assign reg_ptr   = ptr_q;
  assign reg_wr    = wr_q;
  assign reg_wdata = wdata_q;
  assign busy      = state_q != SMBSP_IDLE;
  assign own_addr  = match_addr;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  strap_fixed_a: assert property (
    $rose(strap_done_q) && locked_q == 1'b0 && $past(mode_sync_q[1])
    |-> sel_addr_q == SMBSP_ADDR_FIXED)
    else $error("fixed address not chosen");
  strap_sel_a: assert property (
    $rose(strap_done_q) && !$past(mode_sync_q[1])
    |-> sel_addr_q == ($past(choice_sync_q[1]) ? SMBSP_ADDR_SEL1
                                               : SMBSP_ADDR_SEL0))
    else $error("selected address wrong");
  lock_hold_a: assert property (
    locked_q |=> locked_q && $stable(lock_addr_q))
    else $error("latched address changed");
  start_addr_a: assert property (
    start_ev && !stop_ev && !timeout |=> state_q == SMBSP_ADDR
    && bit_q == 4'h0)
    else $error("start did not restart address");
  ack_drive_a: assert property (
    state_q == SMBSP_ADDR && scl_fall && bit_q == SMBSP_BIT_ACK
    && addr_hit && !start_ev && !stop_ev && !timeout
    |=> sda_oe)
    else $error("no acknowledge on match");
  miss_release_a: assert property (
    state_q == SMBSP_SKIP |-> !sda_oe)
    else $error("data driven while unaddressed");
  ptr_keep_a: assert property (
    state_q != SMBSP_WDAT |=> $stable(ptr_q))
    else $error("pointer changed outside write");
  wr_second_a: assert property (
    reg_wr |-> $past(byte2_q) && $past(state_q) == SMBSP_WDAT)
    else $error("data write on first byte");
  stop_idle_a: assert property (
    stop_ev |=> state_q == SMBSP_IDLE && !sda_oe)
    else $error("stop did not release");
  timeout_a: assert property (
    timeout |=> state_q == SMBSP_IDLE && !sda_oe)
    else $error("timeout did not release");

  addr_ack_c: cover property (state_q == SMBSP_ADDR ##1
                              state_q == SMBSP_ACK);
  data_wr_c:  cover property (reg_wr);
  read_c:     cover property (state_q == SMBSP_RACK);
  miss_c:     cover property (state_q == SMBSP_SKIP);
endmodule : smbsp_port
`default_nettype wire

// *** hdl/smbsp_pkg.sv ***
// Purpose: constants and types for the serial management-bus slave port
// Assumes: 200 MHz core clock
// Notes:   slave addresses are 7-bit, pointer and data are 8-bit
`default_nettype none
package smbsp_pkg;
  localparam logic [6:0] SMBSP_ADDR_FIXED = 7'h2e;
  localparam logic [6:0] SMBSP_ADDR_SEL0  = 7'h2c;
  localparam logic [6:0] SMBSP_ADDR_SEL1  = 7'h2d;
  localparam int         SMBSP_CLK_MHZ    = 200;
  localparam int         SMBSP_TIMEOUT_MS = 35;
  localparam int         SMBSP_TIMEOUT_CYC =
    SMBSP_TIMEOUT_MS * 1000 * SMBSP_CLK_MHZ;
  localparam int         SMBSP_GLITCH_NS  = 50;
  localparam int         SMBSP_FILT_CYC   =
    (SMBSP_GLITCH_NS * SMBSP_CLK_MHZ + 999) / 1000;
  localparam int         SMBSP_CFG_BUS_TIMEOUT_OFF_BIT = 6;
  localparam logic [7:0] SMBSP_PTR_RST    = 8'h00;
  localparam logic [3:0] SMBSP_BIT_LAST   = 4'h7;
  localparam logic [3:0] SMBSP_BIT_ACK    = 4'h8;

  typedef enum logic [2:0] {
    SMBSP_IDLE  = 3'b000,
    SMBSP_ADDR  = 3'b001,
    SMBSP_ACK   = 3'b011,
    SMBSP_WDAT  = 3'b010,
    SMBSP_RDAT  = 3'b110,
    SMBSP_RACK  = 3'b111,
    SMBSP_SKIP  = 3'b101
  } smbsp_state_t;
endpackage : smbsp_pkg
`default_nettype wire

// *** hdl/smbsp_filter.sv ***
// Purpose: two-flop synchroniser and glitch filter for one bus line
// Assumes: line idles high
// Notes:   output changes only after the input held FILT+1 cycles
`default_nettype none
module smbsp_filter
  import smbsp_pkg::*;
#(
  parameter int FILT = SMBSP_FILT_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic line_in,
  output logic      line_out
);
  logic       s1_q;
  logic       s2_q;
  logic [4:0] cnt_q;
  logic       out_q;
  wire        differ = s2_q != out_q;
  wire        done   = cnt_q >= 5'(FILT);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q  <= 1'b1;
      s2_q  <= 1'b1;
      cnt_q <= 5'h00;
      out_q <= 1'b1;
    end else begin
      s1_q <= line_in;
      s2_q <= s1_q;
      cnt_q <= (differ && !done) ? cnt_q + 5'h01 : 5'h00;
      if (differ && done) begin
        out_q <= s2_q;
      end
    end
  end
  assign line_out = out_q;
endmodule : smbsp_filter
`default_nettype wire

// *** sim/smbsp_master.sv ***
// Purpose: behavioural bus master for the slave port
// Assumes: data line pulled up; sda_low high pulls it down
// Notes:   clock stands still between frames; slowed past the deglitcher
`default_nettype none
module smbsp_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter bit of 160 ns: a 32 ns half period would be filtered away
  localparam int QCYC = 32;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (QCYC) @(negedge clk);
  endtask : q
  // data moves only with clock low
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bit_io
  task automatic start_c();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start_c
  task automatic stop_c();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask : stop_c
  // eight bits then a released ninth: ack on writes, no-ack on reads
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx,
                       output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
    ack = !a;
  endtask : xbyte
endmodule : smbsp_master
`default_nettype wire

// *** sim/smbus_slave_register_port_tb_top.sv ***
// Purpose: self-checking bench for the slave port
// Assumes: register store modelled by a fixed scramble of the pointer
// Notes:   timeout shortened to 2000 cycles
`default_nettype none
module smbus_slave_register_port_tb_top;
  import smbsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, sys_rst, mode, choice, to_off, m_low, m_scl;
  logic       sda_out, sda_oe, reg_wr, busy, ack;
  logic [7:0] reg_ptr, reg_wdata, p1, d1, p2, rx, wr_ptr, wr_dat;
  logic [6:0] own_addr;
  wire        sda = !((sda_oe && !sda_out) || m_low);
  int         num_errors, total_checks, wr_cnt;
  function automatic logic [7:0] mem(logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'h5a;
  endfunction : mem
  function automatic logic [7:0] exp_addr(logic m, logic c);
    return m ? 8'h2e : (c ? 8'h2d : 8'h2c);
  endfunction : exp_addr
  smbsp_port #(.TIMEOUT_CYC(2000)) DUT (
    .clk(clk), .sys_rst(sys_rst), .scl_in(m_scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_mode_strap(mode),
    .address_choice_strap(choice), .bus_timeout_off(to_off),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(mem(reg_ptr)), .busy(busy), .own_addr(own_addr));
  smbsp_master u_m (.clk(clk), .sda(sda), .scl(m_scl), .sda_low(m_low));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  always @(negedge clk) if (reg_wr === 1'b1) begin
    wr_cnt++;
    wr_ptr = reg_ptr;
    wr_dat = reg_wdata;
  end
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // whole frame: address, optional read byte or up to two write bytes
  task automatic txn(input logic [6:0] a, input logic rd, input int n,
                     input logic [7:0] p, d);
    logic       k;
    logic [7:0] x;
    u_m.start_c();
    u_m.xbyte({a, rd}, x, ack);
    if (rd) u_m.xbyte(8'hff, rx, k);
    if (n > 0) u_m.xbyte(p, x, k);
    if (n > 1) u_m.xbyte(d, x, k);
    u_m.stop_c();
  endtask : txn
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {mode, choice, to_off, wr_cnt} = '0;
    sys_rst = 1'b1;
    void'($urandom(32'h587e));
    p1 = $urandom;
    d1 = $urandom;
    p2 = $urandom;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      {mode, choice} = (i == 0) ? 2'b10 : ((i == 1) ? 2'b00 : 2'b01);
      sys_rst = 1'b1;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      check("own_addr", {1'b0, own_addr}, exp_addr(mode, choice));
      check("ptr_rst", reg_ptr, 8'h00);
    end
    $display("test straps done");
    choice = 1'b0;
    txn(7'h2c, 1'b0, 2, p1, d1);
    check("nack_other", {7'h0, ack}, 8'h00);
    check("no_write", wr_cnt[7:0], 8'h00);
    txn(7'h2d, 1'b0, 2, p1, d1);
    check("ack_own", {7'h0, ack}, 8'h01);
    check("wr_cnt", wr_cnt[7:0], 8'h01);
    check("wr_ptr", wr_ptr, p1);
    check("wr_dat", wr_dat, d1);
    check("kept_addr", {1'b0, own_addr}, 8'h2d);
    $display("test write done");
    txn(7'h2d, 1'b0, 1, p2, 8'h00);
    check("ptr_only", reg_ptr, p2);
    check("ptr_no_wr", wr_cnt[7:0], 8'h01);
    for (int i = 0; i < 2; i++) begin
      txn(7'h2d, 1'b1, 0, 8'h00, 8'h00);
      check("read_ack", {7'h0, ack}, 8'h01);
      check("read_dat", rx, mem(p2));
    end
    $display("test read done");
    u_m.start_c();
    u_m.xbyte(8'h5a, rx, ack);
    for (int i = 0; i < 3; i++) u_m.bit_io(1'b0, ack);
    txn(7'h2d, 1'b1, 0, 8'h00, 8'h00);
    check("restart_dat", rx, mem(p2));
    check("restart_ptr", reg_ptr, p2);
    $display("test restart done");
    to_off = 1'b1;
    u_m.start_c();
    u_m.xbyte(8'h5a, rx, ack);
    repeat (3000) @(negedge clk);
    check("busy_held", {7'h0, busy}, 8'h01);
    to_off = 1'b0;
    repeat (3000) @(negedge clk);
    check("busy_freed", {7'h0, busy}, 8'h00);
    check("sda_freed", {7'h0, sda_oe}, 8'h00);
    u_m.stop_c();
    $display("test timeout done");
    report_and_stop();
  end
endmodule : smbus_slave_register_port_tb_top
`default_nettype wire
